// ===== bmcr_regs.sv
// control and status register bank of the battery monitor
// Behaviour
// - config register at 0x64, fixed bit layout
// - amp-off bit one switches amplifier off
// - time counter wrap toggles its flag
// - power-down sleeps only below selected threshold
// - threshold select resets to all ones
// - config bit 0 reads zero, reset zero
// - clear register at 0x63, fixed bit layout
// - power-loss flag set on supply drop, writable
// - status bit drives open drain, resets one
// - bit 4 clears charge time and flag
// - bit 3 clears discharge time and flag
// - bits 2..0 clear counter pairs, self-clearing
// - command register at 0x62, zero when done
// - program command ANDs data into flash
// - erase commands wipe pages 0, 1, 2
// - RAM copied into flash page 0
// - flash page 0 copied into RAM
// - power-down sleeps until line edge
// - temperature nine bits across 0x61, 0x60
// - temperature high upper bits read zero
// - target address 0x70, write data 0x6F
// - slow count rate after a wrap
// - clearing restores default count rate
`timescale 1ns/1ps
`include "bmcr_defs.svh"
module bmcr_regs
  import bmcr_pkg::*;
#(
  parameter int TICK_CYCLES = `BMCR_TICK_CYCLES,
  parameter int NVM_BYTES   = 96
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire bmcr_req_t  req,
  output bmcr_rsp_t       rsp,
  input  wire logic       single_wire_line,
  input  wire logic       sense_below_thr,
  input  wire logic       supply_low,
  input  wire logic       charge_active,
  input  wire logic       discharge_active,
  input  wire logic [8:0] die_temp,
  output logic [2:0]      sleep_threshold_sel,
  output logic            reg_amp_on,
  output logic            asleep,
  output bmcr_clr_t       counter_clr,
  output logic            stat_out,
  output logic            stat_oe_n,
  output logic [15:0]     charge_time_counter,
  output logic [15:0]     discharge_time_counter
);

  // ==========================================
  // storage
  logic [7:0]  flash_mem [NVM_BYTES];
  logic [7:0]  ram_mem [`BMCR_PAGE_BYTES];
  logic [7:0]  nvm_command;
  logic [7:0]  flash_target_addr;
  logic [7:0]  flash_write_data;
  logic        cfg_rsvd;
  logic        reg_amp_off;
  logic        clr_rsvd;
  logic        pwr_loss;
  logic        stat_bit;
  logic [4:0]  clr_pend;
  logic        charge_time_wrap_flag;
  logic        discharge_time_wrap_flag;
  bmcr_state_t state;
  logic [4:0]  idx;
  logic [1:0]  erase_page;
  logic [27:0] tick_cnt;
  logic        tick;
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic        line_prev;

  wire wr_cmd = req.wr && req.addr == `BMCR_OFF_NVM_CMD;
  wire wr_clr = req.wr && req.addr == `BMCR_OFF_CLR_CTL;
  wire wr_cfg = req.wr && req.addr == `BMCR_OFF_SLEEP_CFG;

  // ==========================================
  // pin synchronisers
  // analog comparators and the line are outside the clock domain
  // comparator result as input
  always_ff @(posedge clk) begin
    sync1 <= {single_wire_line, sense_below_thr, supply_low,
              charge_active, discharge_active};
    sync2 <= sync1;
  end

  logic line_s, below_s, supply_low_s, chg_s, dsg_s;
  assign {line_s, below_s, supply_low_s, chg_s, dsg_s} = sync2;
  always_ff @(posedge clk) begin
    if (srst) begin
      line_prev <= 1'b1;
    end else begin
      line_prev <= line_s;
    end
  end

  // ==========================================
  // internal timebase
  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt <= 28'h0000000;
      tick     <= 1'b0;
    end else if (tick_cnt == 28'(TICK_CYCLES - 1)) begin
      tick_cnt <= 28'h0000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 28'h0000001;
      tick     <= 1'b0;
    end
  end

  // ==========================================
  // time counters
  // charge time cleared with its flag
  bmcr_time_counter #(
    .W (16)
  ) u_charge_time (
    .clk       (clk),
    .srst      (srst),
    .tick      (tick),
    .active    (chg_s),
    .clear     (clr_pend[`BMCR_CLR_CTC]),
    .count     (charge_time_counter),
    .wrap_flag (charge_time_wrap_flag)
  );

  bmcr_time_counter #(
    .W (16)
  ) u_discharge_time (
    .clk       (clk),
    .srst      (srst),
    .tick      (tick),
    .active    (dsg_s),
    .clear     (clr_pend[`BMCR_CLR_DTC]),
    .count     (discharge_time_counter),
    .wrap_flag (discharge_time_wrap_flag)
  );

  // ==========================================
  // sleep and regulator configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rsvd            <= 1'b0;
      reg_amp_off         <= 1'b0;
      sleep_threshold_sel <= `BMCR_RST_THR;
    end else if (wr_cfg) begin
      cfg_rsvd            <= req.wdata[`BMCR_CFG_RSVD];
      reg_amp_off         <= req.wdata[`BMCR_CFG_AMP_OFF];
      sleep_threshold_sel <=
        req.wdata[`BMCR_CFG_THR_HI:`BMCR_CFG_THR_LO];
    end
  end
  assign reg_amp_on = ~reg_amp_off;

  // ==========================================
  // counter clear control
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_rsvd <= 1'b0;
      stat_bit <= `BMCR_RST_STAT;
    end else if (wr_clr) begin
      clr_rsvd <= req.wdata[`BMCR_CLR_RSVD];
      stat_bit <= req.wdata[`BMCR_CLR_STAT];
    end
  end

  // supply drop sets, host may write
  // reset stands for power-on, so the flag starts set
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_loss <= 1'b1;
    end else if (supply_low_s) begin
      pwr_loss <= 1'b1;
    end else if (wr_clr) begin
      pwr_loss <= req.wdata[`BMCR_CLR_PWR_LOSS];
    end
  end

  // clear bits act then self-clear
  // a new write in the clearing cycle wins and repeats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_pend <= 5'h00;
    end else if (wr_clr) begin
      clr_pend <= req.wdata[4:0];
    end else begin
      clr_pend <= 5'h00;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      counter_clr <= '0;
    end else begin
      counter_clr <= '{self_discharge: clr_pend[2],
                       charge:         clr_pend[1],
                       discharge:      clr_pend[0]};
    end
  end
  // one releases open drain, zero pulls
  assign stat_out  = 1'b0;
  assign stat_oe_n = stat_bit;

  // ==========================================
  // flash address and data
  // target address and write data
  always_ff @(posedge clk) begin
    if (srst) begin
      flash_target_addr <= 8'h00;
      flash_write_data  <= 8'h00;
    end else if (req.wr) begin
      if (req.addr == `BMCR_OFF_TGT_ADDR) begin
        flash_target_addr <= req.wdata;
      end
      if (req.addr == `BMCR_OFF_WR_DATA) begin
        flash_write_data <= req.wdata;
      end
    end
  end

  // ==========================================
  // command sequencer
  // writes while a command runs are ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      nvm_command <= `BMCR_CMD_NONE;
      state       <= NVM_IDLE;
      idx         <= 5'h00;
      erase_page  <= 2'h0;
    end else begin
      unique case (state)
        NVM_IDLE: begin
          idx <= 5'h00;
          if (wr_cmd) begin
            nvm_command <= req.wdata;
            case (req.wdata)
              `BMCR_CMD_ERASE0,
              `BMCR_CMD_ERASE1,
              `BMCR_CMD_ERASE2: begin
                state      <= NVM_ERASE;
                erase_page <= req.wdata[1:0];
              end
              `BMCR_CMD_RAM2FL: state <= NVM_TO_FLASH;
              `BMCR_CMD_FL2RAM: state <= NVM_TO_RAM;
              `BMCR_CMD_PWRDN: begin
                if (below_s) begin
                  state <= NVM_SLEEP;
                end else begin
                  nvm_command <= `BMCR_CMD_NONE;
                end
              end
              default: nvm_command <= `BMCR_CMD_NONE;
            endcase
          end
        end
        NVM_ERASE,
        NVM_TO_FLASH,
        NVM_TO_RAM: begin
          idx <= idx + 5'h01;
          if (&idx) begin
            state       <= NVM_IDLE;
            nvm_command <= `BMCR_CMD_NONE;
          end
        end
        NVM_SLEEP: begin
          if (line_s != line_prev) begin
            state       <= NVM_IDLE;
            nvm_command <= `BMCR_CMD_NONE;
          end
        end
      endcase
    end
  end
  assign asleep = state == NVM_SLEEP;

  // ==========================================
  // flash array, no reset: contents are nonvolatile
  // top address bit checked too, so high targets cannot alias
  wire  [6:0] erase_addr = {erase_page, idx};
  wire  [6:0] prog_addr  = flash_target_addr[6:0];
  always_ff @(posedge clk) begin
    if (state == NVM_IDLE && wr_cmd && req.wdata == `BMCR_CMD_PROG
        && !flash_target_addr[7] && prog_addr <= `BMCR_FLASH_TOP) begin
      flash_mem[prog_addr] <= flash_mem[prog_addr] & flash_write_data;
    end
    if (state == NVM_ERASE) begin
      flash_mem[erase_addr] <= `BMCR_ERASED;
    end
    if (state == NVM_TO_FLASH) begin
      flash_mem[idx] <= ram_mem[idx];
    end
  end

  // ==========================================
  // general-purpose RAM, host writes at page 0 offsets
  always_ff @(posedge clk) begin
    if (state == NVM_TO_RAM) begin
      ram_mem[idx] <= flash_mem[idx];
    end else if (req.wr && req.addr < 7'(`BMCR_PAGE_BYTES)) begin
      ram_mem[req.addr[4:0]] <= req.wdata;
    end
  end

  // ==========================================
  // read path
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (req.addr < 7'(`BMCR_PAGE_BYTES)) begin
      next_rdata = ram_mem[req.addr[4:0]];
    end else if (req.addr <= `BMCR_FLASH_TOP) begin
      next_rdata = flash_mem[req.addr];
    end else begin
      unique case (req.addr)
        `BMCR_OFF_TEMP_LO: next_rdata = die_temp[7:0];
        `BMCR_OFF_TEMP_HI: next_rdata = {7'h00, die_temp[8]};
        `BMCR_OFF_NVM_CMD: next_rdata = nvm_command;
        `BMCR_OFF_CLR_CTL:
          next_rdata = {clr_rsvd, pwr_loss, stat_bit, clr_pend};
        `BMCR_OFF_SLEEP_CFG:
          next_rdata = {cfg_rsvd, reg_amp_off, charge_time_wrap_flag,
                        discharge_time_wrap_flag, sleep_threshold_sel,
                        1'b0};
        `BMCR_OFF_CTC_LO:   next_rdata = charge_time_counter[7:0];
        `BMCR_OFF_CTC_HI:   next_rdata = charge_time_counter[15:8];
        `BMCR_OFF_DTC_LO:   next_rdata = discharge_time_counter[7:0];
        `BMCR_OFF_DTC_HI:   next_rdata = discharge_time_counter[15:8];
        `BMCR_OFF_WR_DATA:  next_rdata = flash_write_data;
        `BMCR_OFF_TGT_ADDR: next_rdata = flash_target_addr;
        default:            next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.rd;
      if (req.rd) begin
        rsp.data <= next_rdata;
      end
    end
  end

endmodule

// ===== bmcr_defs.svh
// constants of the battery monitor control register bank
`ifndef BMCR_DEFS_SVH
`define BMCR_DEFS_SVH

// ==========================================
// register offsets
`define BMCR_OFF_TEMP_LO    7'h60
`define BMCR_OFF_TEMP_HI    7'h61
`define BMCR_OFF_NVM_CMD    7'h62
`define BMCR_OFF_CLR_CTL    7'h63
`define BMCR_OFF_SLEEP_CFG  7'h64
`define BMCR_OFF_CTC_LO     7'h65
`define BMCR_OFF_CTC_HI     7'h66
`define BMCR_OFF_DTC_LO     7'h67
`define BMCR_OFF_DTC_HI     7'h68
`define BMCR_OFF_WR_DATA    7'h6F
`define BMCR_OFF_TGT_ADDR   7'h70
`define BMCR_FLASH_TOP      7'h5F
`define BMCR_PAGE_BYTES     32

// ==========================================
// field positions
`define BMCR_CFG_RSVD       7
`define BMCR_CFG_AMP_OFF    6
`define BMCR_CFG_CT_WRAP    5
`define BMCR_CFG_DT_WRAP    4
`define BMCR_CFG_THR_HI     3
`define BMCR_CFG_THR_LO     1
`define BMCR_CLR_RSVD       7
`define BMCR_CLR_PWR_LOSS   6
`define BMCR_CLR_STAT       5
`define BMCR_CLR_CTC        4
`define BMCR_CLR_DTC        3

// ==========================================
// reset and erase values
`define BMCR_RST_THR        3'h7
`define BMCR_RST_STAT       1'b1
`define BMCR_ERASED         8'hFF

// ==========================================
// command codes
`define BMCR_CMD_NONE       8'h00
`define BMCR_CMD_PROG       8'h0F
`define BMCR_CMD_ERASE0     8'h40
`define BMCR_CMD_ERASE1     8'h41
`define BMCR_CMD_ERASE2     8'h42
`define BMCR_CMD_RAM2FL     8'h45
`define BMCR_CMD_FL2RAM     8'h48
`define BMCR_CMD_PWRDN      8'hF6

// ==========================================
// timing
`define BMCR_CLK_NS         5
`define BMCR_TICK_NS        878900000
`define BMCR_TICK_CYCLES    (`BMCR_TICK_NS / `BMCR_CLK_NS)
`define BMCR_SLOW_DIV       256

`endif

// ===== bmcr_pkg.sv
// types shared by the battery monitor control register bank
package bmcr_pkg;

  // ==========================================
  // decoded register access from the serial line
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bmcr_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bmcr_rsp_t;

  // ==========================================
  // one-cycle clear strobes for the counter datapaths
  typedef struct packed {
    logic self_discharge;
    logic charge;
    logic discharge;
  } bmcr_clr_t;

  typedef enum logic [2:0] {
    NVM_IDLE,
    NVM_ERASE,
    NVM_TO_FLASH,
    NVM_TO_RAM,
    NVM_SLEEP
  } bmcr_state_t;

endpackage

// ===== bmcr_time_counter.sv
// 16-bit time counter with wrap flag and slow rate after a wrap
`timescale 1ns/1ps
`include "bmcr_defs.svh"
module bmcr_time_counter
  import bmcr_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         tick,
  input  wire logic         active,
  input  wire logic         clear,
  output logic [W-1:0]      count,
  output logic              wrap_flag
);

  logic [7:0] prescale;

  // ==========================================
  // counting
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      count     <= '0;
      wrap_flag <= 1'b0;
      prescale  <= 8'h00;
    end else if (tick && active) begin
      // 256 ticks per count once wrapped
      if (wrap_flag && prescale != 8'(`BMCR_SLOW_DIV - 1)) begin
        prescale <= prescale + 8'h01;
      end else begin
        prescale <= 8'h00;
        count    <= count + W'(1);
        // wrap past all ones toggles flag
        if (&count) begin
          wrap_flag <= ~wrap_flag;
        end
      end
    end
  end

endmodule

// ===== bmcr_regs_monitor.sv
// assertion checker for the battery monitor register bank
`timescale 1ns/1ps
module bmcr_regs_monitor
  import bmcr_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int NVM_BYTES   = 96
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire bmcr_req_t   req,
  input  wire bmcr_rsp_t   rsp,
  input  wire logic [8:0]  die_temp,
  input  wire logic [2:0]  sleep_threshold_sel,
  input  wire logic        reg_amp_on,
  input  wire logic        asleep,
  input  wire bmcr_clr_t   counter_clr,
  input  wire logic        stat_oe_n,
  input  wire logic [15:0] charge_time_counter
);
  // ==========
  // write and read decodes
  logic cfg_wr;
  logic clr_wr;
  logic pd_wr;
  logic rd_hi;
  logic rd_lo;
  assign cfg_wr = req.wr && req.addr == 7'h64;
  assign clr_wr = req.wr && req.addr == 7'h63;
  assign pd_wr  = req.wr && req.addr == 7'h62 && req.wdata == 8'hF6;
  assign rd_hi  = req.rd && req.addr == 7'h61;
  assign rd_lo  = req.rd && req.addr == 7'h60;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ==========
  // properties
  property p_amp;
    cfg_wr |=> reg_amp_on == !$past(req.wdata[6]);
  endproperty
  a_amp: assert property (p_amp) else $error("amp state");
  property p_thr;
    cfg_wr |=> sleep_threshold_sel == $past(req.wdata[3:1]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold");
  property p_thi;
    rd_hi |=> rsp.valid && rsp.data == {7'h00, $past(die_temp[8])};
  endproperty
  a_thi: assert property (p_thi) else $error("temp high");
  property p_tlo;
    rd_lo |=> rsp.valid && rsp.data == $past(die_temp[7:0]);
  endproperty
  a_tlo: assert property (p_tlo) else $error("temp low");
  property p_stat;
    clr_wr |=> stat_oe_n == $past(req.wdata[5]);
  endproperty
  a_stat: assert property (p_stat) else $error("status pin");
  property p_ctc;
    clr_wr && req.wdata[4] |-> ##[2:3] charge_time_counter == 16'h0000;
  endproperty
  a_ctc: assert property (p_ctc) else $error("time clear");
  property p_pulse;
    clr_wr && req.wdata[1] |-> ##[1:3] counter_clr.charge
      ##1 !counter_clr.charge;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear pulse");
  property p_sleep;
    $rose(asleep) |-> $past(pd_wr);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep cause");
  property p_reset;
    $fell(srst) |-> sleep_threshold_sel == 3'h7 && stat_oe_n && reg_amp_on;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
endmodule

bind bmcr_regs bmcr_regs_monitor #(
  .TICK_CYCLES (TICK_CYCLES),
  .NVM_BYTES   (NVM_BYTES)
) bmcr_regs_monitor_inst (
  .clk                 (clk),
  .srst                (srst),
  .req                 (req),
  .rsp                 (rsp),
  .die_temp            (die_temp),
  .sleep_threshold_sel (sleep_threshold_sel),
  .reg_amp_on          (reg_amp_on),
  .asleep              (asleep),
  .counter_clr         (counter_clr),
  .stat_oe_n           (stat_oe_n),
  .charge_time_counter (charge_time_counter)
);

// ===== bmcr_host.sv
// host controller model driving register requests and the line
`timescale 1ns/1ps
module bmcr_host
  import bmcr_pkg::*;
(
  input  wire logic      clk,
  input  wire bmcr_rsp_t rsp,
  output bmcr_req_t      req,
  output logic           single_wire_line
);
  initial begin
    req = '0;
    single_wire_line = 1'b1;
  end
  // ==========
  // requests held until the taking edge
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rsp.valid ? rsp.data : 8'hXX;
  endtask
  function automatic logic [7:0] cfg(input logic [7:0] old,
                                     input logic       amp,
                                     input logic [2:0] thr);
    return {old[7], amp, 2'b00, ((thr == 3'h0) ? 3'h1 : thr), 1'b0};
  endfunction
  // line idles high; a low pulse gives two edges
  task automatic wake();
    @(posedge clk);
    single_wire_line <= 1'b0;
    repeat (4) @(posedge clk);
    single_wire_line <= 1'b1;
  endtask
endmodule

// ===== tb_battery_monitor_control_regs.sv
// self-checking bench for the battery monitor register bank
`timescale 1ns/1ps
module tb_battery_monitor_control_regs;
  import bmcr_pkg::*;
  logic        clk, srst, sense_below_thr, supply_low;
  logic        charge_active, discharge_active, single_wire_line;
  logic        reg_amp_on, asleep, stat_out, stat_oe_n;
  logic [8:0]  die_temp;
  logic [2:0]  sleep_threshold_sel;
  logic [15:0] charge_time_counter, discharge_time_counter;
  logic [7:0]  d, v;
  bmcr_req_t   req;
  bmcr_rsp_t   rsp;
  bmcr_clr_t   counter_clr;
  int          errors, checks, cycles;
  int unsigned seed = 16390;
  int          ram_m[$];

  bmcr_regs #(.TICK_CYCLES(4), .NVM_BYTES(96)) bmcr_regs_inst (
    .clk, .srst, .req, .rsp, .single_wire_line, .sense_below_thr,
    .supply_low, .charge_active, .discharge_active, .die_temp,
    .sleep_threshold_sel, .reg_amp_on, .asleep, .counter_clr,
    .stat_out, .stat_oe_n, .charge_time_counter, .discharge_time_counter);
  bmcr_host bmcr_host_inst (.clk, .rsp, .req, .single_wire_line);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========
  // helpers
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] g, e, m);
    checks++;
    if ((g & m) !== (e & m)) begin
      errors++;
      $display("MISMATCH %0t reg %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, m);
    bmcr_host_inst.rd_reg(a, d);
    chk_reg(d, e, m);
  endtask
  // polls the command register, bounded
  task automatic cmd(input logic [7:0] c);
    int n;
    bmcr_host_inst.wr_reg(7'h62, c);
    n = 0;
    d = 8'hFF;
    while (d !== 8'h00 && n < 40) begin
      bmcr_host_inst.rd_reg(7'h62, d);
      n++;
    end
    chk_reg(d, 8'h00, 8'hFF);
  endtask
  // whole run needs about a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ==========
  // scenarios
  initial begin
    srst = 1'b1;
    sense_below_thr = 1'b0;
    supply_low = 1'b0;
    charge_active = 1'b0;
    discharge_active = 1'b0;
    die_temp = 9'h000;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    die_temp <= 9'(rnd());
    @(negedge clk);
    chk_reg({5'h00, sleep_threshold_sel}, 8'h07, 8'hFF);
    chk_bit(stat_oe_n, 1'b1);
    chk_bit(reg_amp_on, 1'b1);
    chk_bit(stat_out, 1'b0);
    rd_chk(7'h64, 8'h0E, 8'h7F);
    rd_chk(7'h63, 8'h60, 8'h7F);
    rd_chk(7'h62, 8'h00, 8'hFF);
    rd_chk(7'h61, {7'h00, die_temp[8]}, 8'hFF);
    rd_chk(7'h60, die_temp[7:0], 8'hFF);
    rd_chk(7'h75, 8'h00, 8'hFF);
    for (int i = 1; i < 8; i++) begin
      bmcr_host_inst.rd_reg(7'h64, d);
      v = bmcr_host_inst.cfg(d, i[0], i[2:0]);
      bmcr_host_inst.wr_reg(7'h64, v);
      rd_chk(7'h64, {1'b0, i[0], 2'b00, i[2:0], 1'b0}, 8'h7F);
      chk_bit(reg_amp_on, ~i[0]);
      chk_bit(sleep_threshold_sel == i[2:0], 1'b1);
    end
    bmcr_host_inst.wr_reg(7'h63, 8'h40);
    @(negedge clk);
    chk_bit(stat_oe_n, 1'b0);
    bmcr_host_inst.wr_reg(7'h63, 8'h20);
    rd_chk(7'h63, 8'h20, 8'h7F);
    @(posedge clk);
    supply_low <= 1'b1;
    charge_active <= 1'b1;
    discharge_active <= 1'b1;
    repeat (200) @(posedge clk);
    supply_low <= 1'b0;
    charge_active <= 1'b0;
    discharge_active <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(7'h63, 8'h60, 8'h7F);
    for (int a = 5; a < 8; a += 2) begin
      bmcr_host_inst.rd_reg(7'h60 + 7'(a), d);
      chk_bit(d >= 8'h28 && d <= 8'h34, 1'b1);
    end
    bmcr_host_inst.wr_reg(7'h63, 8'h38);
    repeat (3) @(posedge clk);
    rd_chk(7'h63, 8'h20, 8'h7F);
    for (int a = 5; a < 9; a++) rd_chk(7'h60 + 7'(a), 8'h00, 8'hFF);
    bmcr_host_inst.wr_reg(7'h63, 8'h27);
    repeat (2) @(negedge clk);
    chk_reg({5'h00, counter_clr}, 8'h07, 8'hFF);
    repeat (3) @(posedge clk);
    rd_chk(7'h63, 8'h20, 8'h7F);
    for (int a = 0; a < 32; a++) begin
      ram_m.push_back(rnd() & 32'hFF);
      bmcr_host_inst.wr_reg(7'(a), 8'(ram_m[a]));
    end
    cmd(8'h40);
    cmd(8'h45);
    for (int a = 0; a < 32; a++) bmcr_host_inst.wr_reg(7'(a), ~8'(ram_m[a]));
    cmd(8'h48);
    for (int a = 0; a < 32; a++) rd_chk(7'(a), 8'(ram_m[a]), 8'hFF);
    for (int p = 1; p < 3; p++) begin
      cmd(8'h40 + 8'(p));
      rd_chk(7'(32 * p), 8'hFF, 8'hFF);
      rd_chk(7'(32 * p + 31), 8'hFF, 8'hFF);
    end
    bmcr_host_inst.wr_reg(7'h70, 8'h3F);
    for (int k = 0; k < 2; k++) begin
      d = 8'(rnd());
      v = (k == 0) ? d : (v & d);
      bmcr_host_inst.wr_reg(7'h6F, d);
      cmd(8'h0F);
      rd_chk(7'h3F, v, 8'hFF);
    end
    // a target above the flash range must not alias onto it
    bmcr_host_inst.wr_reg(7'h6F, 8'h00);
    bmcr_host_inst.wr_reg(7'h70, 8'hBF);
    rd_chk(7'h70, 8'hBF, 8'hFF);
    cmd(8'h0F);
    rd_chk(7'h3F, v, 8'hFF);
    bmcr_host_inst.wr_reg(7'h62, 8'h33);
    rd_chk(7'h62, 8'h00, 8'hFF);
    bmcr_host_inst.wr_reg(7'h62, 8'hF6);
    rd_chk(7'h62, 8'h00, 8'hFF);
    chk_bit(asleep, 1'b0);
    @(posedge clk);
    sense_below_thr <= 1'b1;
    repeat (4) @(posedge clk);
    bmcr_host_inst.wr_reg(7'h62, 8'hF6);
    repeat (20) @(negedge clk);
    chk_bit(asleep, 1'b1);
    bmcr_host_inst.wake();
    repeat (8) @(negedge clk);
    chk_bit(asleep, 1'b0);
    rd_chk(7'h62, 8'h00, 8'hFF);
    close_out();
  end
endmodule
